// [rtl/pic_io_port.sv]
// Instruction decode, skip answers, transfers and subsystem interrupt mask
`timescale 1ns/1ps
module proc_io_port
    import proc_io_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire bus_instr_t i_instr,
    input wire logic [WORD_W-1:0] i_host_word,
    input wire logic i_ready,
    input wire logic [WORD_W-1:0] i_adapter_word,
    input wire logic [WORD_W-1:0] i_subsys_req,
    output logic o_skip,
    output logic o_in_valid,
    output logic o_in_clear,
    output logic [WORD_W-1:0] o_in_word,
    output logic [WORD_W-1:0] o_out_word,
    output out_strobe_t o_out_strobe,
    output logic [WORD_W-1:0] o_irq_enable,
    output logic [WORD_W-1:0] o_irq_pending,
    output logic [WORD_W-1:0] o_irq_ack,
    output logic o_irq
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] ready_sync_q;
    logic [1:0] ready_sync_d;
    logic [WORD_W-1:0] req_meta_q;
    logic [WORD_W-1:0] req_sync_q;
    logic [WORD_W-1:0] req_meta_d;
    logic [WORD_W-1:0] req_sync_d;

    always_comb
    begin
        ready_sync_d = {ready_sync_q[0], i_ready};
        req_meta_d = i_subsys_req;
        req_sync_d = req_meta_q;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            ready_sync_q <= 2'b00;
            req_meta_q <= '0;
            req_sync_q <= '0;
        end
        else
        begin
            ready_sync_q <= ready_sync_d;
            req_meta_q <= req_meta_d;
            req_sync_q <= req_sync_d;
        end
    end

    logic ready;
    assign ready = ready_sync_q[1];

    // ****************************************
    // Instruction decode
    // ****************************************
    logic [WORD_W-1:0] named;
    subsys_decode u_decode
    (
        .i_code(i_instr.func),
        .o_onehot(named)
    );

    logic is_ctl;
    logic is_skip;
    logic is_in;
    logic is_out;
    assign is_ctl = i_instr.valid && i_instr.kind == KIND_CONTROL;
    assign is_skip = i_instr.valid && i_instr.kind == KIND_SKIP;
    assign is_in = i_instr.valid && i_instr.kind == KIND_INPUT && i_instr.dev == DEV_READY;
    assign is_out = i_instr.valid && i_instr.kind == KIND_OUTPUT;

    // ****************************************
    // Interrupt state and transfers
    // ****************************************
    logic [WORD_W-1:0] enable_q;
    logic [WORD_W-1:0] enable_d;
    logic [WORD_W-1:0] pend_q;
    logic [WORD_W-1:0] pend_d;
    logic [WORD_W-1:0] ack_q;
    logic [WORD_W-1:0] ack_d;
    logic irq_q;
    logic irq_d;
    logic skip_q;
    logic skip_d;
    logic in_valid_q;
    logic in_valid_d;
    logic in_clear_q;
    logic in_clear_d;
    logic [WORD_W-1:0] in_word_q;
    logic [WORD_W-1:0] in_word_d;
    logic [WORD_W-1:0] out_word_q;
    logic [WORD_W-1:0] out_word_d;
    out_strobe_t strobe_q;
    out_strobe_t strobe_d;

    always_comb
    begin
        enable_d = enable_q;
        ack_d = '0;
        skip_d = 1'b0;
        in_valid_d = 1'b0;
        in_clear_d = 1'b0;
        in_word_d = in_word_q;
        out_word_d = out_word_q;
        strobe_d = '0;
        // Control pulse acknowledges only the named subsystem
        if (is_ctl && i_instr.dev == DEV_INTR)
        begin
            ack_d = named;                                             // [R1]
        end
        // Requests arriving with the acknowledge win over the clear
        pend_d = (pend_q & ~ack_d) | (req_sync_q & enable_q & SUBSYS_VALID);   // [R1] [R12]
        if (is_skip)
        begin
            if (i_instr.dev == DEV_READY && i_instr.func == FN_ZERO)
            begin
                skip_d = ready;                                        // [R2] [R15]
            end
            else if (i_instr.dev == DEV_INTR && i_instr.func == FN_ZERO)
            begin
                skip_d = (pend_q == '0);                               // [R3]
            end
            else if (i_instr.dev == DEV_INTR)
            begin
                skip_d = (named != '0) && ((pend_q & named) == '0);    // [R4]
            end
        end
        // Ready-gated input; adapter and host do the merge or clear
        if (is_in && ready && (i_instr.func == FN_ZERO || i_instr.func == FN_CLEAR_IN))
        begin
            in_valid_d = 1'b1;                                         // [R5] [R15]
            in_clear_d = (i_instr.func == FN_CLEAR_IN);                // [R6]
            in_word_d = i_adapter_word;                                // [R5] [R6]
            skip_d = 1'b1;                                             // [R13]
        end
        if (is_out && i_instr.dev == DEV_READY && ready)
        begin
            // Analog read is select then output-and-cycle
            case (i_instr.func)
                FN_SEL:
                begin
                    strobe_d.sel = 1'b1;                               // [R7] [R14]
                    out_word_d = i_host_word;
                    skip_d = 1'b1;
                end
                FN_DATA:
                begin
                    strobe_d.data = 1'b1;                              // [R8]
                    out_word_d = i_host_word;
                    skip_d = 1'b1;
                end
                FN_CYCLE:
                begin
                    strobe_d.cycle = 1'b1;                             // [R9] [R14]
                    out_word_d = i_host_word;
                    skip_d = 1'b1;
                end
                default:
                begin
                    skip_d = 1'b0;                                     // [R15]
                end
            endcase
        end
        // Mask load is not ready-gated
        if (is_out && i_instr.dev == DEV_INTR && i_instr.func == FN_MASK)
        begin
            enable_d = i_host_word & SUBSYS_VALID;                     // [R10] [R12]
            skip_d = 1'b1;
        end
        irq_d = (pend_d != '0);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            enable_q <= MASK_RESET;
            pend_q <= '0;
            ack_q <= '0;
            irq_q <= 1'b0;
            skip_q <= 1'b0;
            in_valid_q <= 1'b0;
            in_clear_q <= 1'b0;
            in_word_q <= '0;
            out_word_q <= '0;
            strobe_q <= '0;
        end
        else
        begin
            enable_q <= enable_d;
            pend_q <= pend_d;
            ack_q <= ack_d;
            irq_q <= irq_d;
            skip_q <= skip_d;
            in_valid_q <= in_valid_d;
            in_clear_q <= in_clear_d;
            in_word_q <= in_word_d;
            out_word_q <= out_word_d;
            strobe_q <= strobe_d;
        end
    end

    assign o_skip = skip_q;
    assign o_in_valid = in_valid_q;
    assign o_in_clear = in_clear_q;
    assign o_in_word = in_word_q;
    assign o_out_word = out_word_q;
    assign o_out_strobe = strobe_q;
    assign o_irq_enable = enable_q;
    assign o_irq_pending = pend_q;
    assign o_irq_ack = ack_q;
    assign o_irq = irq_q;

endmodule

// [rtl/pic_io_pkg.sv]
// Constants, types and instruction codes for the process I/O controller front end
// Function
// [R1] Control pulse clears named subsystem's pending interrupt
// [R2] Ready skip test skips only while ready
// [R3] Global skip test skips when none interrupting
// [R4] Subsystem skip test skips when named not interrupting
// [R5] Plain input drives adapter word when ready
// [R6] Clearing input: host clears, device supplies word
// [R7] Select output accepted only while ready
// [R8] Data output accepted only while ready
// [R9] Output-and-cycle accepts word, starts cycle, ready
// [R10] Mask-load output loads interrupt enable from word
// [R11] Code field decodes the ten listed subsystems
// [R12] Mask bits 1-5, 11-15 enable subsystems
// [R13] Decode instructions; adapter supplies all timing
// [R14] Analog read: select, then output-and-cycle
// [R15] Not ready: no transfer, no skip
package proc_io_pkg;

    localparam int WORD_W = 16;
    localparam int FUNC_W = 4;
    localparam int CODE_W = 6;

    // Instruction classes on the I/O bus
    typedef enum logic [1:0] {
        KIND_CONTROL = 2'b00,
        KIND_SKIP = 2'b01,
        KIND_INPUT = 2'b11,
        KIND_OUTPUT = 2'b10
    } instr_kind_t;

    // Device codes; field is octal function digits then device code
    localparam logic [CODE_W-1:0] DEV_READY = 6'h13;
    localparam logic [CODE_W-1:0] DEV_INTR = 6'h1B;

    localparam logic [FUNC_W-1:0] FN_ZERO = 4'h0;
    localparam logic [FUNC_W-1:0] FN_SEL = 4'h1;
    localparam logic [FUNC_W-1:0] FN_DATA = 4'h3;
    localparam logic [FUNC_W-1:0] FN_CYCLE = 4'h7;
    localparam logic [FUNC_W-1:0] FN_CLEAR_IN = 4'h8;
    localparam logic [FUNC_W-1:0] FN_MASK = 4'h8;

    localparam logic [WORD_W-1:0] MASK_RESET = 16'h0000;
    // Subsystems own mask bits 1-5 and 11-15; codes 11-15 octal land on bits 11-15
    localparam logic [WORD_W-1:0] SUBSYS_VALID = 16'hF83E;

    typedef struct packed {
        logic valid;
        instr_kind_t kind;
        logic [FUNC_W-1:0] func;
        logic [CODE_W-1:0] dev;
    } bus_instr_t;

    typedef struct packed {
        logic sel;
        logic data;
        logic cycle;
    } out_strobe_t;

endpackage

// [rtl/pic_subsys_decode.sv]
// Decoder from subsystem code field to one-hot subsystem line
`timescale 1ns/1ps
module subsys_decode
    import proc_io_pkg::*;
(
    input wire logic [FUNC_W-1:0] i_code,
    output logic [WORD_W-1:0] o_onehot
);
    always_comb
    begin
        o_onehot = '0;
        // Octal 01-05 and 11-15 map to bits 1-5 and 11-15
        if (i_code[2:0] != 3'h0 && i_code[2:0] <= 3'h5 && i_code[3:3] == 1'b0)
        begin
            o_onehot[i_code[2:0]] = 1'b1;                              // [R11]
        end
        else if (i_code[2:0] != 3'h0 && i_code[2:0] <= 3'h5)
        begin
            o_onehot[{1'b0, i_code[2:0]} + 4'h8 + 4'h2] = 1'b1;        // [R11]
        end
    end
endmodule

// [tb/pic_io_port_asserts.sv]
// Concurrent checks on the process I/O port
`timescale 1ns/1ps
module proc_io_port_asserts
    import proc_io_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire bus_instr_t i_instr,
    input wire logic [WORD_W-1:0] i_host_word,
    input wire logic i_ready,
    input wire logic [WORD_W-1:0] i_adapter_word,
    input wire logic o_skip,
    input wire logic o_in_valid,
    input wire logic [WORD_W-1:0] o_in_word,
    input wire logic [WORD_W-1:0] o_out_word,
    input wire out_strobe_t o_out_strobe,
    input wire logic [WORD_W-1:0] o_irq_enable,
    input wire logic [WORD_W-1:0] o_irq_pending,
    input wire logic [WORD_W-1:0] o_irq_ack
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // Ready held long enough to pass the synchroniser
    sequence rdy_s; i_ready [*4]; endsequence
    sequence busy_s; !i_ready [*4]; endsequence
    sequence op_s(k, f, d);
        i_instr.valid && i_instr.kind == k && i_instr.func == f && i_instr.dev == d;
    endsequence
    a_sel_taken: assert property (rdy_s ##0 op_s(KIND_OUTPUT, FN_SEL, DEV_READY)
        |=> o_out_strobe.sel && o_skip && o_out_word == $past(i_host_word)) else $error("sel");
    a_input_taken: assert property (rdy_s ##0 op_s(KIND_INPUT, FN_ZERO, DEV_READY)
        |=> o_in_valid && o_skip && o_in_word == $past(i_adapter_word)) else $error("in");
    a_busy_refused: assert property (busy_s ##0 i_instr.valid && i_instr.dev == DEV_READY
        |=> !o_skip && !o_in_valid && o_out_strobe == '0) else $error("busy");
    a_skip_cause: assert property (o_skip |-> $past(i_instr.valid)) else $error("skip");
    a_mask_load: assert property (op_s(KIND_OUTPUT, FN_MASK, DEV_INTR)
        |=> o_irq_enable == ($past(i_host_word) & 16'hF83E)) else $error("mask");
    a_ack_bit: assert property (op_s(KIND_CONTROL, 4'h1, DEV_INTR)
        |=> o_irq_ack == 16'h0002) else $error("ack");
    a_global_skip: assert property (op_s(KIND_SKIP, FN_ZERO, DEV_INTR)
        |=> o_skip == ($past(o_irq_pending) == '0)) else $error("gskip");
    a_pend_masked: assert property ((o_irq_pending & ~$past(o_irq_pending)
        & ~(o_irq_enable | $past(o_irq_enable))) == '0) else $error("pend");
endmodule
bind proc_io_port proc_io_port_asserts chk
(
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_instr(i_instr),
    .i_host_word(i_host_word),
    .i_ready(i_ready),
    .i_adapter_word(i_adapter_word),
    .o_skip(o_skip),
    .o_in_valid(o_in_valid),
    .o_in_word(o_in_word),
    .o_out_word(o_out_word),
    .o_out_strobe(o_out_strobe),
    .o_irq_enable(o_irq_enable),
    .o_irq_pending(o_irq_pending),
    .o_irq_ack(o_irq_ack)
);

// [tb/host_model.sv]
// Host processor model issuing I/O instructions and keeping an accumulator
`timescale 1ns/1ps
module host_model
    import proc_io_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_in_valid,
    input wire logic i_in_clear,
    input wire logic [WORD_W-1:0] i_in_word,
    output bus_instr_t o_instr,
    output logic [WORD_W-1:0] o_word
);
    logic [WORD_W-1:0] acc = '0;
    initial
    begin
        o_instr = '0;
        o_word = '0;
    end
    // One-cycle instruction; released word is inverted so stale data shows
    task issue(input instr_kind_t k, input logic [3:0] f, input logic [5:0] d,
               input logic [15:0] w);
        @(posedge i_clk);
        o_instr <= '{1'b1, k, f, d};
        o_word <= w;
        @(posedge i_clk);
        o_instr <= '0;
        o_word <= ~w;
        // Preload here, clear of the edge where an earlier input merges
        acc <= w;
        #1;
    endtask
    always @(posedge i_clk)
        if (i_in_valid === 1'b1)
            acc <= i_in_clear ? i_in_word : (acc | i_in_word);
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the process I/O port
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_top
    import proc_io_pkg::*;
;
    logic i_mclk = 0, i_sys_rst = 1, i_ready = 0, o_skip, o_in_valid, o_in_clear, o_irq;
    logic [15:0] i_adapter_word = 16'hA5C3, i_subsys_req = '0, i_host_word;
    logic [15:0] o_in_word, o_out_word, o_irq_enable, o_irq_pending, o_irq_ack;
    bus_instr_t i_instr;
    out_strobe_t o_out_strobe;
    int fail_count = 0, compares = 0, cyc = 0;
    always #20 i_mclk = ~i_mclk;
    proc_io_port uut
    (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_instr(i_instr),
        .i_host_word(i_host_word),
        .i_ready(i_ready),
        .i_adapter_word(i_adapter_word),
        .i_subsys_req(i_subsys_req),
        .o_skip(o_skip),
        .o_in_valid(o_in_valid),
        .o_in_clear(o_in_clear),
        .o_in_word(o_in_word),
        .o_out_word(o_out_word),
        .o_out_strobe(o_out_strobe),
        .o_irq_enable(o_irq_enable),
        .o_irq_pending(o_irq_pending),
        .o_irq_ack(o_irq_ack),
        .o_irq(o_irq)
    );
    host_model host (.i_clk(i_mclk), .i_in_valid(o_in_valid), .i_in_clear(o_in_clear),
        .i_in_word(o_in_word), .o_instr(i_instr), .o_word(i_host_word));
    task close_out;
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Change ready and requests, then let the synchronisers settle
    task set_in(input logic r, input logic [15:0] q);
        @(posedge i_mclk);
        i_ready <= r;
        i_subsys_req <= q;
        repeat (4) @(posedge i_mclk);
        #1;
    endtask
    task t_ready_ops;
        set_in(1'b1, '0);
        host.issue(KIND_OUTPUT, FN_SEL, DEV_READY, 16'h0123);
        `CHK("sel", {4'h9, 16'h0123}, {o_out_strobe, o_skip, o_out_word})
        host.issue(KIND_OUTPUT, FN_CYCLE, DEV_READY, 16'h4567);
        `CHK("cyc", {4'h3, 16'h4567}, {o_out_strobe, o_skip, o_out_word})
        host.issue(KIND_OUTPUT, FN_DATA, DEV_READY, 16'h89AB);
        `CHK("data", 4'h5, {o_out_strobe, o_skip})
        host.issue(KIND_INPUT, FN_ZERO, DEV_READY, 16'h1000);
        `CHK("in", {3'b101, 16'hA5C3}, {o_in_valid, o_in_clear, o_skip, o_in_word})
        @(posedge i_mclk);
        #1;
        `CHK("merge", 16'hB5C3, host.acc)
        host.issue(KIND_INPUT, FN_CLEAR_IN, DEV_READY, 16'hFFFF);
        `CHK("inclr", 3'b111, {o_in_valid, o_in_clear, o_skip})
        @(posedge i_mclk);
        #1;
        `CHK("acc", 16'hA5C3, host.acc)
        host.issue(KIND_SKIP, FN_ZERO, DEV_READY, '0);
        `CHK("rdy", 1'b1, o_skip)
    endtask
    task t_not_ready;
        set_in(1'b0, '0);
        host.issue(KIND_OUTPUT, FN_DATA, DEV_READY, 16'h5555);
        `CHK("nr_out", {4'h0, 16'h89AB}, {o_out_strobe, o_skip, o_out_word})
        host.issue(KIND_INPUT, FN_ZERO, DEV_READY, '0);
        `CHK("nr_in", 2'b00, {o_in_valid, o_skip})
        host.issue(KIND_SKIP, FN_ZERO, DEV_READY, '0);
        `CHK("nr_skip", 1'b0, o_skip)
    endtask
    task t_irq;
        host.issue(KIND_OUTPUT, FN_MASK, DEV_INTR, 16'hFFFF);
        `CHK("mask", {1'b1, 16'hF83E}, {o_skip, o_irq_enable})
        set_in(1'b0, 16'h8002);
        `CHK("pend", 16'h8002, o_irq_pending)
        host.issue(KIND_SKIP, FN_ZERO, DEV_INTR, '0);
        `CHK("gskip", 2'b10, {o_irq, o_skip})
        host.issue(KIND_SKIP, 4'h1, DEV_INTR, '0);
        `CHK("sskip1", 1'b0, o_skip)
        host.issue(KIND_SKIP, 4'h2, DEV_INTR, '0);
        `CHK("sskip2", 1'b1, o_skip)
        host.issue(KIND_CONTROL, 4'h1, DEV_INTR, '0);
        `CHK("ack_held", {16'h0002, 16'h8002}, {o_irq_ack, o_irq_pending})
        set_in(1'b0, '0);
        host.issue(KIND_CONTROL, 4'h1, DEV_INTR, '0);
        `CHK("ack1", {16'h0002, 16'h8000}, {o_irq_ack, o_irq_pending})
        host.issue(KIND_CONTROL, 4'hD, DEV_INTR, '0);
        `CHK("ack15", {16'h8000, 16'h0000}, {o_irq_ack, o_irq_pending})
        host.issue(KIND_SKIP, FN_ZERO, DEV_INTR, '0);
        `CHK("gskip0", 2'b01, {o_irq, o_skip})
    endtask
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 1000)
        begin
            fail_count++;
            close_out;
        end
    end
    initial
    begin
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        t_ready_ops;
        t_not_ready;
        t_irq;
        close_out;
    end
endmodule
